// [shared/isbi_map.svh]
/*
  Bit positions, reset values and counts for the two-wire slave byte
  interface. Included by the top-level design file alone; holds
  definitions only.
*/
`ifndef ISBI_MAP_SVH
`define ISBI_MAP_SVH

// Control register field positions
`define ISBI_CTRL_EN_POS     7
`define ISBI_CTRL_TXMODE_POS 4
`define ISBI_CTRL_SEND_ACK_CTRL_POS   3

// Reset values
`define ISBI_CTRL_RST        8'h00
`define ISBI_ADDR_RST        8'h00
`define ISBI_DATA_RST        8'h00

// Own address lives in bits 7..1, bit 0 is don't care
`define ISBI_ADDR_MSB        7
`define ISBI_ADDR_LSB        1

// Bit counter: index of the eighth bit of a byte
`define ISBI_LAST_BIT        3'h7
`define ISBI_CNT_RST         3'h0

`endif

// [shared/isbi_pkg.sv]
/*
  Types for the two-wire slave byte interface.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package isbi_pkg;

  // Byte engine states, one-hot
  typedef enum logic [7:0] {
    ISBI_IDLE    = 8'b0000_0001,
    ISBI_ADDR    = 8'b0000_0010,
    ISBI_ADDR_AK = 8'b0000_0100,
    ISBI_HOLD    = 8'b0000_1000,
    ISBI_TX      = 8'b0001_0000,
    ISBI_TX_AK   = 8'b0010_0000,
    ISBI_RX      = 8'b0100_0000,
    ISBI_RX_AK   = 8'b1000_0000
  } isbi_state_e;

  // Width of the control and data bytes
  typedef logic [7:0] isbi_byte_t;

endpackage : isbi_pkg

// [logic/isbi_sync.sv]
/*
  Two flip-flop synchroniser, parameterised width.
  Assumes its inputs come from another clock domain or from pins.
*/
`timescale 1ns/1ps
module isbi_sync #(
  parameter int W = 2
) (
  input  wire logic         i_mclk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Lines idle high, so reset to ones
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule : isbi_sync

// [logic/isbi_cond_det.sv]
/*
  Finds clock edges and START / STOP conditions on the bus.
  Assumes both inputs are already synchronised to i_mclk.
*/
`timescale 1ns/1ps
module isbi_cond_det (
  input  wire logic i_mclk,
  input  wire logic i_srst,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop
);

  logic scl_q;
  logic sda_q;

  // Previous samples
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Edges; data changes with the clock high are conditions
  assign o_scl_rise = i_scl & ~scl_q;
  assign o_scl_fall = ~i_scl & scl_q;
  assign o_start    = i_scl & scl_q & sda_q & ~i_sda;
  assign o_stop     = i_scl & scl_q & ~sda_q & i_sda;

endmodule : isbi_cond_det

// [logic/isbi_top.sv]
/*
  Slave-only two-wire byte interface: address compare, acknowledge,
  8-bit shifting through one data register, clock stretching until
  software services that register.
  Assumes a 20 MHz i_mclk well above the bus clock, an external master
  making START, STOP and SCL, and pull-ups on both lines.
*/
`timescale 1ns/1ps
`include "isbi_map.svh"
module isbi_top #(
  parameter bit BUS_FUNC_EN = 1'b1
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_scl,
  input  wire logic             i_sda,
  output logic                  o_scl_out,
  output logic                  o_scl_oe_n,
  output logic                  o_sda_out,
  output logic                  o_sda_oe_n,
  input  wire logic             i_addr_wr,
  input  wire isbi_pkg::isbi_byte_t i_addr_wdata,
  input  wire logic             i_ctrl_wr,
  input  wire isbi_pkg::isbi_byte_t i_ctrl_wdata,
  input  wire logic             i_data_wr,
  input  wire isbi_pkg::isbi_byte_t i_data_wdata,
  input  wire logic             i_data_rd,
  output isbi_pkg::isbi_byte_t  o_serial_data_reg,
  output isbi_pkg::isbi_byte_t  o_own_addr_reg,
  output isbi_pkg::isbi_byte_t  o_bus_control_reg,
  output logic                  o_byte_done_flag,
  output logic                  o_addr_matched_flag,
  output logic                  o_bus_busy_flag,
  output logic                  o_master_read_dir_flag,
  output logic                  o_recv_ack_flag,
  output logic                  o_bus_event
);
  import isbi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Line sampling and condition detection

  logic [1:0] lines_sync;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  isbi_sync #(
    .W (2)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_async ({i_scl, i_sda}),
    .o_sync  (lines_sync)
  );

  assign scl_s = lines_sync[1];
  assign sda_s = lines_sync[0];

  isbi_cond_det u_det (
    .i_mclk     (i_mclk),
    .i_srst     (i_srst),
    .i_scl      (scl_s),
    .i_sda      (sda_s),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start_det),
    .o_stop     (stop_det)
  );

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Open-drain drive: a zero bit pulls low, a one releases
  function automatic logic od_oe_n(input logic bit_val);
    od_oe_n = bit_val;
  endfunction : od_oe_n

  ////////////////////////////////////////////////////////////////////////
  // State

  isbi_state_e state_q, state_d;
  isbi_byte_t  sdr_q, sdr_d;
  isbi_byte_t  addr_q, addr_d;
  isbi_byte_t  ctrl_q, ctrl_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        scl_oe_n_q, scl_oe_n_d;
  logic        sda_oe_n_q, sda_oe_n_d;
  logic        done_q, done_d;
  logic        match_q, match_d;
  logic        busy_q, busy_d;
  logic        dir_q, dir_d;
  logic        recv_ack_flag_q, recv_ack_flag_d;
  logic        event_q, event_d;
  logic        enabled;
  logic        addr_hit;
  logic        serviced;

  // build option and enable bit gate the bus side; register writes are not gated
  assign enabled  = BUS_FUNC_EN & ctrl_q[`ISBI_CTRL_EN_POS];
  // compare bits seven to one only
  assign addr_hit = (sdr_q[`ISBI_ADDR_MSB:`ISBI_ADDR_LSB]
                     == addr_q[`ISBI_ADDR_MSB:`ISBI_ADDR_LSB]);
  // service is a data write in transmit, a read in receive
  assign serviced = ctrl_q[`ISBI_CTRL_TXMODE_POS] ? i_data_wr : i_data_rd;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_d    = state_q;
    sdr_d      = sdr_q;
    addr_d     = addr_q;
    ctrl_d     = ctrl_q;
    cnt_d      = cnt_q;
    scl_oe_n_d = scl_oe_n_q;
    sda_oe_n_d = sda_oe_n_q;
    done_d     = done_q;
    match_d    = match_q;
    busy_d     = busy_q;
    dir_d      = dir_q;
    recv_ack_flag_d     = recv_ack_flag_q;
    event_d    = 1'b0;

    // Software side writes
    if (i_addr_wr) begin
      addr_d = i_addr_wdata;
    end
    // single data register, loaded by software
    if (i_data_wr) begin
      sdr_d = i_data_wdata;
    end
    // control write clears match; a same-cycle set below wins
    if (i_ctrl_wr) begin
      ctrl_d  = i_ctrl_wdata;
      match_d = 1'b0;
    end

    if (!enabled) begin
      // Disabled: let go of both lines and forget the transfer
      state_d    = ISBI_IDLE;
      scl_oe_n_d = 1'b1;
      sda_oe_n_d = 1'b1;
      busy_d     = 1'b0;
      cnt_d      = `ISBI_CNT_RST;
    end else if (stop_det) begin
      busy_d     = 1'b0;
      state_d    = ISBI_IDLE;
      scl_oe_n_d = 1'b1;
      sda_oe_n_d = 1'b1;
    end else if (start_det) begin
      // START marks the bus busy; also restarts on repeat START
      busy_d     = 1'b1;
      state_d    = ISBI_ADDR;
      cnt_d      = `ISBI_CNT_RST;
      scl_oe_n_d = 1'b1;
      sda_oe_n_d = 1'b1;
    end else begin
      case (state_q)
        ISBI_IDLE: begin
          // foreign address or idle, wait for START
          sda_oe_n_d = 1'b1;
        end
        ISBI_ADDR: begin
          // shift address and direction, MSB first
          if (scl_rise) begin
            sdr_d = {sdr_q[6:0], sda_s};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `ISBI_LAST_BIT) begin
              state_d = ISBI_ADDR_AK;
            end
          end
        end
        ISBI_ADDR_AK: begin
          // Eighth bit in; decide on the falling edge that follows
          if (scl_fall) begin
            if (addr_hit) begin
              // event, match flag, direction, acknowledge low
              match_d    = 1'b1;
              event_d    = 1'b1;
              // direction bit one means master reads
              dir_d      = sdr_q[0];
              sda_oe_n_d = od_oe_n(1'b0);
              state_d    = ISBI_HOLD;
              cnt_d      = `ISBI_CNT_RST;
            end else begin
              // not ours, stay off the bus
              state_d = ISBI_IDLE;
            end
          end
        end
        ISBI_HOLD: begin
          // Ninth slot ends (ack or not) before the clock is stretched
          if (scl_fall && scl_oe_n_q) begin
            sda_oe_n_d = 1'b1;
            scl_oe_n_d = 1'b0;
          end else if (!scl_oe_n_q && serviced) begin
            // software serviced the register, let SCL go
            scl_oe_n_d = 1'b1;
            // cleared while the next byte moves
            done_d     = 1'b0;
            cnt_d      = `ISBI_CNT_RST;
            if (ctrl_q[`ISBI_CTRL_TXMODE_POS]) begin
              // first bit out is the MSB of the written byte
              sda_oe_n_d = od_oe_n(i_data_wdata[7]);
              state_d    = ISBI_TX;
            end else begin
              sda_oe_n_d = 1'b1;
              state_d    = ISBI_RX;
            end
          end
        end
        ISBI_TX: begin
          // next bit on each falling edge
          if (scl_fall) begin
            sdr_d = {sdr_q[6:0], 1'b0};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `ISBI_LAST_BIT) begin
              // Ninth slot belongs to the master
              sda_oe_n_d = 1'b1;
              state_d    = ISBI_TX_AK;
            end else begin
              sda_oe_n_d = od_oe_n(sdr_q[6]);
            end
          end
        end
        ISBI_TX_AK: begin
          // SDA already released; a missing acknowledge reads high
          if (scl_rise) begin
            recv_ack_flag_d = sda_s;
          end
          if (scl_fall) begin
            done_d     = 1'b1;
            event_d    = 1'b1;
            scl_oe_n_d = 1'b0;
            state_d    = ISBI_HOLD;
          end
        end
        ISBI_RX: begin
          // sample on rising edges, MSB first
          if (scl_rise) begin
            sdr_d = {sdr_q[6:0], sda_s};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == `ISBI_LAST_BIT) begin
              state_d = ISBI_RX_AK;
            end
          end
        end
        ISBI_RX_AK: begin
          if (scl_fall) begin
            // acknowledge level from the control bit
            sda_oe_n_d = od_oe_n(ctrl_q[`ISBI_CTRL_SEND_ACK_CTRL_POS]);
            done_d     = 1'b1;
            event_d    = 1'b1;
            state_d    = ISBI_HOLD;
          end
        end
        default: begin
          state_d    = ISBI_IDLE;
          scl_oe_n_d = 1'b1;
          sda_oe_n_d = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q    <= ISBI_IDLE;
      sdr_q      <= `ISBI_DATA_RST;
      addr_q     <= `ISBI_ADDR_RST;
      ctrl_q     <= `ISBI_CTRL_RST;
      cnt_q      <= `ISBI_CNT_RST;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      done_q     <= 1'b0;
      match_q    <= 1'b0;
      busy_q     <= 1'b0;
      dir_q      <= 1'b0;
      recv_ack_flag_q     <= 1'b0;
      event_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      sdr_q      <= sdr_d;
      addr_q     <= addr_d;
      ctrl_q     <= ctrl_d;
      cnt_q      <= cnt_d;
      scl_oe_n_q <= scl_oe_n_d;
      sda_oe_n_q <= sda_oe_n_d;
      done_q     <= done_d;
      match_q    <= match_d;
      busy_q     <= busy_d;
      dir_q      <= dir_d;
      recv_ack_flag_q     <= recv_ack_flag_d;
      event_q    <= event_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops, out levels tied to zero; pins only ever pull low

  assign o_scl_out              = 1'b0;
  assign o_sda_out              = 1'b0;
  assign o_scl_oe_n             = scl_oe_n_q;
  assign o_sda_oe_n             = sda_oe_n_q;
  assign o_serial_data_reg      = sdr_q;
  assign o_own_addr_reg         = addr_q;
  assign o_bus_control_reg      = ctrl_q;
  assign o_byte_done_flag       = done_q;
  assign o_addr_matched_flag    = match_q;
  assign o_bus_busy_flag        = busy_q;
  assign o_master_read_dir_flag = dir_q;
  assign o_recv_ack_flag        = recv_ack_flag_q;
  assign o_bus_event            = event_q;

endmodule : isbi_top

// [tb/isbi_top_monitor.sv]
/*
  Concurrent checks on the ports of the slave byte interface top.
  Assumes one clock domain, i_mclk, with synchronous reset i_srst.
*/
`timescale 1ns/1ps
module isbi_top_monitor (
  input wire logic                 i_mclk,
  input wire logic                 i_srst,
  input wire logic                 o_scl_oe_n,
  input wire logic                 o_sda_oe_n,
  input wire logic                 i_addr_wr,
  input wire isbi_pkg::isbi_byte_t i_addr_wdata,
  input wire logic                 i_ctrl_wr,
  input wire isbi_pkg::isbi_byte_t i_ctrl_wdata,
  input wire logic                 i_data_wr,
  input wire isbi_pkg::isbi_byte_t i_data_wdata,
  input wire logic                 i_data_rd,
  input wire isbi_pkg::isbi_byte_t o_serial_data_reg,
  input wire isbi_pkg::isbi_byte_t o_own_addr_reg,
  input wire isbi_pkg::isbi_byte_t o_bus_control_reg,
  input wire logic                 o_byte_done_flag,
  input wire logic                 o_addr_matched_flag,
  input wire logic                 o_bus_busy_flag,
  input wire logic                 o_bus_event
);
  import isbi_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////////
  // Stretch phases: held with no service, or serviced in right mode
  sequence s_held_quiet;
    !o_scl_oe_n && !i_data_rd && !i_data_wr && !i_ctrl_wr;
  endsequence
  sequence s_service;
    !o_scl_oe_n && !i_ctrl_wr &&
    ((i_data_rd && !o_bus_control_reg[4]) || (i_data_wr && o_bus_control_reg[4]));
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_EVENT_PULSE: assert property (o_bus_event |=> !o_bus_event)
    else $error("bus event wider than one cycle");
  AST_MATCH_ACK: assert property ($rose(o_addr_matched_flag) |-> ##[0:2] !o_sda_oe_n)
    else $error("no acknowledge after address match");
  AST_CTRL_CLEAR: assert property (i_ctrl_wr |=> !o_addr_matched_flag || o_bus_event)
    else $error("control write left match flag set");
  AST_CTRL_REG: assert property (i_ctrl_wr |=>
    (o_bus_control_reg & 8'h98) == ($past(i_ctrl_wdata) & 8'h98))
    else $error("control register not written");
  AST_ADDR_REG: assert property (i_addr_wr |=>
    o_own_addr_reg[7:1] == $past(i_addr_wdata[7:1]))
    else $error("own address not written");
  AST_DISABLED: assert property ((!o_bus_control_reg[7]) [*3] |->
    o_sda_oe_n && o_scl_oe_n && !o_bus_busy_flag)
    else $error("bus active while disabled");
  AST_STRETCH_HOLD: assert property (s_held_quiet |=> !o_scl_oe_n)
    else $error("clock released without service");
  AST_RELEASE: assert property (s_service |=> o_scl_oe_n && !o_byte_done_flag)
    else $error("clock not released after service");
  AST_DATA_WR: assert property (i_data_wr |=> o_serial_data_reg == $past(i_data_wdata))
    else $error("data register not written");
  AST_DONE_EVENT: assert property ($rose(o_byte_done_flag) |-> o_bus_event)
    else $error("byte done without bus event");
endmodule : isbi_top_monitor
bind isbi_top isbi_top_monitor isbi_top_monitor_inst (
  .i_mclk(i_mclk), .i_srst(i_srst), .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n),
  .i_addr_wr(i_addr_wr), .i_addr_wdata(i_addr_wdata), .i_ctrl_wr(i_ctrl_wr),
  .i_ctrl_wdata(i_ctrl_wdata), .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata),
  .i_data_rd(i_data_rd), .o_serial_data_reg(o_serial_data_reg),
  .o_own_addr_reg(o_own_addr_reg), .o_bus_control_reg(o_bus_control_reg),
  .o_byte_done_flag(o_byte_done_flag), .o_addr_matched_flag(o_addr_matched_flag),
  .o_bus_busy_flag(o_bus_busy_flag), .o_bus_event(o_bus_event));

// [tb/isbi_master_model.sv]
/*
  Behavioural two-wire bus master: START, STOP, 9-bit byte slots.
  Assumes pull-ups resolved outside; waits while the slave stretches SCL.
*/
`timescale 1ns/1ps
module isbi_master_model (
  input  wire logic i_scl_w,
  input  wire logic i_sda_w,
  output logic      o_scl_drv,
  output logic      o_sda_drv
);
  // Lines released at start, clock stands still between frames
  initial begin
    o_scl_drv = 1'b1;
    o_sda_drv = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////
  // One bit slot; odd delays keep edges off the system clock
  task automatic clk_bit(input logic b, output logic r);
    #100;
    o_sda_drv = b;
    #100;
    o_scl_drv = 1'b1;
    wait (i_scl_w);
    #107;
    r = i_sda_w;
    #100;
    o_scl_drv = 1'b0;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic ak_seen);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(ak, ak_seen);
  endtask : xfer
  // only master starts, SDA falls with SCL high
  task automatic start_cond();
    #100;
    o_sda_drv = 1'b1;
    #100;
    o_scl_drv = 1'b1;
    wait (i_scl_w);
    #107;
    o_sda_drv = 1'b0;
    #200;
    o_scl_drv = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    #100;
    o_sda_drv = 1'b0;
    #100;
    o_scl_drv = 1'b1;
    wait (i_scl_w);
    #107;
    o_sda_drv = 1'b1;
    #200;
  endtask : stop_cond
endmodule : isbi_master_model

// [tb/isbi_top_tb.sv]
/*
  Self-checking bench: software strobes plus a bus master model.
  Assumes wired-AND lines with pull-ups and a 20 MHz system clock.
*/
`timescale 1ns/1ps
module isbi_top_tb;
  import isbi_pkg::*;
  logic       i_mclk, i_srst, i_addr_wr, i_ctrl_wr, i_data_wr, i_data_rd, ak;
  logic       o_scl_out, o_scl_oe_n, o_sda_out, o_sda_oe_n, m_scl, m_sda, scl_w, sda_w;
  logic       o_byte_done_flag, o_addr_matched_flag, o_bus_busy_flag;
  logic       o_master_read_dir_flag, o_recv_ack_flag, o_bus_event;
  isbi_byte_t i_addr_wdata, i_ctrl_wdata, i_data_wdata, q;
  isbi_byte_t o_serial_data_reg, o_own_addr_reg, o_bus_control_reg;
  int         num_errors, checked, cycles;
  // Pull-ups: a line is low if any party pulls it
  assign scl_w = m_scl & (o_scl_oe_n | o_scl_out);
  assign sda_w = m_sda & (o_sda_oe_n | o_sda_out);
  ////////////////////////////////////////////////////////////////////
  isbi_top isbi_top_inst (.i_mclk(i_mclk), .i_srst(i_srst), .i_scl(scl_w), .i_sda(sda_w),
    .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .i_addr_wr(i_addr_wr), .i_addr_wdata(i_addr_wdata),
    .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata), .i_data_wr(i_data_wr),
    .i_data_wdata(i_data_wdata), .i_data_rd(i_data_rd), .o_serial_data_reg(o_serial_data_reg),
    .o_own_addr_reg(o_own_addr_reg), .o_bus_control_reg(o_bus_control_reg),
    .o_byte_done_flag(o_byte_done_flag), .o_addr_matched_flag(o_addr_matched_flag),
    .o_bus_busy_flag(o_bus_busy_flag), .o_master_read_dir_flag(o_master_read_dir_flag),
    .o_recv_ack_flag(o_recv_ack_flag), .o_bus_event(o_bus_event));
  isbi_master_model isbi_master_model_inst (.i_scl_w(scl_w), .i_sda_w(sda_w),
    .o_scl_drv(m_scl), .o_sda_drv(m_sda));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Software access: k 0 address, 1 control, 2 data write, 3 data read
  task automatic sw(input int k, input isbi_byte_t d);
    @(posedge i_mclk);
    i_addr_wr    <= (k == 0);
    i_ctrl_wr    <= (k == 1);
    i_data_wr    <= (k == 2);
    i_data_rd    <= (k == 3);
    i_addr_wdata <= d;
    i_ctrl_wdata <= d;
    i_data_wdata <= d;
    @(posedge i_mclk);
    {i_addr_wr, i_ctrl_wr, i_data_wr, i_data_rd} <= 4'h0;
    repeat (2) @(posedge i_mclk);
  endtask : sw
  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    {i_srst, num_errors, checked, cycles} = {1'b1, 96'h0};
    {i_addr_wr, i_ctrl_wr, i_data_wr, i_data_rd} = 4'h0;
    {i_addr_wdata, i_ctrl_wdata, i_data_wdata} = 24'h0;
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    chk("idle", {o_bus_busy_flag, o_addr_matched_flag, o_scl_oe_n, o_sda_oe_n}, 8'h03);
    sw(0, 8'h5A);
    sw(1, 8'h80);
    chk("own_addr", o_own_addr_reg, 8'h5A);
    chk("ctrl", o_bus_control_reg, 8'h80);
    // Master write: address, one acknowledged byte, one refused byte
    isbi_master_model_inst.start_cond();
    chk("busy", o_bus_busy_flag, 1'b1);
    isbi_master_model_inst.xfer(8'h5A, 1'b1, q, ak);
    chk("addr_ack", ak, 1'b0);
    chk("matched", o_addr_matched_flag, 1'b1);
    chk("dir_wr", o_master_read_dir_flag, 1'b0);
    repeat (6) @(posedge i_mclk);
    chk("stretch", o_scl_oe_n, 1'b0);
    sw(1, 8'h80);
    chk("match_clr", o_addr_matched_flag, 1'b0);
    sw(3, 8'h00);
    isbi_master_model_inst.xfer(8'hA5, 1'b1, q, ak);
    repeat (6) @(posedge i_mclk);
    chk("rx_ack", ak, 1'b0);
    chk("rx_data", o_serial_data_reg, 8'hA5);
    chk("rx_done", o_byte_done_flag, 1'b1);
    sw(1, 8'h88);
    sw(3, 8'h00);
    isbi_master_model_inst.xfer(8'h3C, 1'b1, q, ak);
    chk("rx_nack", ak, 1'b1);
    chk("rx_data2", o_serial_data_reg, 8'h3C);
    // Service only once the stretch after the refused byte is in place
    repeat (6) @(posedge i_mclk);
    chk("rx_nack_hold", o_scl_oe_n, 1'b0);
    sw(3, 8'h00);
    isbi_master_model_inst.stop_cond();
    chk("free", o_bus_busy_flag, 1'b0);
    // Master read: two bytes, the second not acknowledged
    isbi_master_model_inst.start_cond();
    isbi_master_model_inst.xfer(8'h5B, 1'b1, q, ak);
    chk("dir_rd", o_master_read_dir_flag, 1'b1);
    sw(1, 8'h90);
    sw(2, 8'hC3);
    isbi_master_model_inst.xfer(8'hFF, 1'b0, q, ak);
    // Flag and stretch land a few cycles after the ninth falling edge
    repeat (6) @(posedge i_mclk);
    chk("tx_data", q, 8'hC3);
    chk("tx_ack", o_recv_ack_flag, 1'b0);
    chk("tx_done", o_byte_done_flag, 1'b1);
    sw(2, 8'h81);
    isbi_master_model_inst.xfer(8'hFF, 1'b1, q, ak);
    chk("tx_data2", q, 8'h81);
    chk("tx_nack", o_recv_ack_flag, 1'b1);
    repeat (6) @(posedge i_mclk);
    chk("sda_free", o_sda_oe_n, 1'b1);
    sw(1, 8'h80);
    sw(3, 8'h00);
    isbi_master_model_inst.stop_cond();
    chk("free2", o_bus_busy_flag, 1'b0);
    // Foreign address, then a byte that looks like ours
    isbi_master_model_inst.start_cond();
    isbi_master_model_inst.xfer(8'h22, 1'b1, q, ak);
    chk("foreign", {ak, o_addr_matched_flag}, 8'h02);
    isbi_master_model_inst.xfer(8'h5A, 1'b1, q, ak);
    chk("ignored", ak, 1'b1);
    isbi_master_model_inst.stop_cond();
    // Disabled interface answers nothing
    sw(1, 8'h00);
    isbi_master_model_inst.start_cond();
    chk("off_busy", o_bus_busy_flag, 1'b0);
    isbi_master_model_inst.xfer(8'h5A, 1'b1, q, ak);
    chk("off_ack", ak, 1'b1);
    isbi_master_model_inst.stop_cond();
    results();
  end
endmodule : isbi_top_tb
